// file: logic/ats_sequencer.sv
// What this block does
// - In normal mode only a qualified trigger event or a force request starts an acquisition.
// - A force request makes exactly one acquisition, as if triggered.
// - In auto mode a timeout timer restarts on every trigger event.
// - In auto mode an expired timeout forces a trigger and acquisition.
// - The auto timeout length is picked by the time base setting.
// - Once a trigger is taken, triggers are ignored until acquisition ends.
// - After each acquisition triggers are ignored for a holdoff interval.
// - Holdoff spans 0 to 100 percent of a range set by the time base.
// - A pretrigger percentage sets the record share before the trigger.
// - A slope setting picks the rising or falling crossing.
// - The delayed trigger path is an edge trigger only.
// - The delayed time base defers acquisition by time, event count or both.
// - Armed keeps pretrigger samples; posttrigger samples follow the event.
// - An edge event is a crossing of the level in the chosen direction.
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer #(
  parameter int unsigned P_AUTO_TO_CYC [ats_pkg::TB_NUM] = '{
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 0),
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 1),
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 2),
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 3),
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 4),
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 5),
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 6),
    ats_pkg::tb_cycles(ats_pkg::AUTO_TO_DIVS, 7)
  },
  parameter int unsigned P_HO_MIN_CYC [ats_pkg::TB_NUM] = '{
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 0),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 1),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 2),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 3),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 4),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 5),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 6),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MIN_DIVS, 7)
  },
  parameter int unsigned P_HO_MAX_CYC [ats_pkg::TB_NUM] = '{
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 0),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 1),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 2),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 3),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 4),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 5),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 6),
    ats_pkg::tb_cycles(ats_pkg::HOLDOFF_MAX_DIVS, 7)
  }
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_trig_cmp,
  input wire logic i_dly_trig_cmp,
  input wire logic i_sample_tick,
  input wire logic i_force,
  input wire ats_pkg::ats_cfg_t i_cfg,
  input wire ats_pkg::ats_dly_cfg_t i_dly_cfg,
  output logic o_sample_we,
  output logic o_trig_mark,
  output logic o_acq_done,
  output logic [2:0] o_state,
  output ats_pkg::ats_status_t o_status
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  ats_pkg::ats_state_t st_r;
  ats_pkg::ats_state_t st_nxt;
  logic [ats_pkg::REC_W-1:0] pre_cnt_r;
  logic [ats_pkg::REC_W-1:0] pre_cnt_nxt;
  logic [ats_pkg::REC_W-1:0] post_cnt_r;
  logic [ats_pkg::REC_W-1:0] post_cnt_nxt;
  logic [ats_pkg::REC_W-1:0] dly_evt_cnt_r;
  logic [ats_pkg::REC_W-1:0] dly_evt_cnt_nxt;
  logic force_pend_r;
  logic force_pend_nxt;
  logic forced_r;
  logic forced_nxt;
  logic sample_we_r;
  logic sample_we_nxt;
  logic trig_mark_r;
  logic trig_mark_nxt;
  logic acq_done_r;
  logic acq_done_nxt;
  ats_pkg::ats_status_t status_r;
  ats_pkg::ats_status_t status_nxt;

  logic main_evt;
  logic dly_evt;
  logic auto_zero;
  logic ho_zero;
  logic dly_zero;
  logic auto_load;
  logic [ats_pkg::CNT_W-1:0] auto_len;
  logic [ats_pkg::CNT_W-1:0] ho_len;
  logic [ats_pkg::REC_W-1:0] pre_len;
  logic [ats_pkg::REC_W-1:0] post_len;
  logic [ats_pkg::PCT_W-1:0] ho_pct;
  logic [ats_pkg::PCT_W-1:0] pre_pct;
  logic pre_full;
  logic accept_ok;
  logic real_trig;
  logic auto_fire;
  logic force_fire;
  logic go;
  logic [31:0] ho_min;
  logic [31:0] ho_span;
  logic [31:0] ho_calc;
  logic [31:0] pre_calc;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection for the main and the delayed trigger paths
  ats_edge_detect u_main_edge (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_cmp(i_trig_cmp),
    .i_slope_fall(i_cfg.slope_fall),
    .o_event(main_evt)
  );

  // Delayed path takes only a plain edge, no qualification
  ats_edge_detect u_dly_edge (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_cmp(i_dly_trig_cmp),
    .i_slope_fall(i_dly_cfg.slope_fall),
    .o_event(dly_evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Lengths derived from time base and percentages
  always_comb begin
    ho_pct = (i_cfg.holdoff_pct > ats_pkg::PCT_FULL) ?
      ats_pkg::PCT_FULL : i_cfg.holdoff_pct;
    pre_pct = (i_cfg.pretrig_pct > ats_pkg::PCT_FULL) ?
      ats_pkg::PCT_FULL : i_cfg.pretrig_pct;
    auto_len = ats_pkg::CNT_W'(P_AUTO_TO_CYC[i_cfg.tb_sel]);
    ho_min = P_HO_MIN_CYC[i_cfg.tb_sel];
    ho_span = P_HO_MAX_CYC[i_cfg.tb_sel] - ho_min;
    ho_calc = ho_min + (ho_span * {25'h0000000, ho_pct}) / 32'h64;
    ho_len = ho_calc[ats_pkg::CNT_W-1:0];
    pre_calc = ({16'h0000, i_cfg.record_len} * {25'h0000000, pre_pct})
      / 32'h64;
    pre_len = pre_calc[ats_pkg::REC_W-1:0];
    post_len = i_cfg.record_len - pre_len;
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger acceptance, only while armed with pretrigger filled
  always_comb begin
    pre_full = (pre_cnt_r >= pre_len);
    accept_ok = (st_r == ats_pkg::ST_ARMED) && pre_full;
    real_trig = accept_ok && main_evt;
    auto_fire = accept_ok && i_cfg.mode_auto && auto_zero && !main_evt;
    force_fire = accept_ok && force_pend_r && !main_evt && !auto_fire;
    go = real_trig || auto_fire || force_fire;
    // Auto timer restarts on each event and after each start
    auto_load = main_evt || go;
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers: auto timeout, holdoff, delayed time
  ats_down_counter u_auto_tmr (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_load(auto_load),
    .i_load_val(auto_len),
    .i_run(i_cfg.mode_auto),
    .o_zero(auto_zero)
  );

  ats_down_counter u_ho_tmr (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_load(acq_done_nxt),
    .i_load_val(ho_len),
    .i_run(st_r == ats_pkg::ST_HOLDOFF),
    .o_zero(ho_zero)
  );

  ats_down_counter u_dly_tmr (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_load(real_trig),
    .i_load_val(i_dly_cfg.time_cyc),
    .i_run(st_r == ats_pkg::ST_DLY_TIME),
    .o_zero(dly_zero)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state and counters
  always_comb begin
    st_nxt = st_r;
    pre_cnt_nxt = pre_cnt_r;
    post_cnt_nxt = post_cnt_r;
    dly_evt_cnt_nxt = dly_evt_cnt_r;
    forced_nxt = forced_r;
    acq_done_nxt = 1'b0;
    trig_mark_nxt = 1'b0;
    // A new request is never lost to the clear of an old one
    force_pend_nxt = (force_pend_r && !force_fire) || i_force;
    case (st_r)
      ats_pkg::ST_ARMED: begin
        if (i_sample_tick && !pre_full) begin
          pre_cnt_nxt = pre_cnt_r + 16'h0001;
        end
        if (go) begin
          forced_nxt = !real_trig;
          post_cnt_nxt = ats_pkg::REC_RST;
          dly_evt_cnt_nxt = ats_pkg::REC_RST;
          if (real_trig && i_dly_cfg.dly_use && i_dly_cfg.by_time) begin
            st_nxt = ats_pkg::ST_DLY_TIME;
          end else if (real_trig && i_dly_cfg.dly_use &&
                       i_dly_cfg.by_events) begin
            st_nxt = ats_pkg::ST_DLY_EVT;
          end else begin
            st_nxt = ats_pkg::ST_ACQ;
            trig_mark_nxt = 1'b1;
          end
        end
      end
      ats_pkg::ST_DLY_TIME: begin
        // Time first, then events when both are chosen
        if (dly_zero) begin
          if (i_dly_cfg.by_events) begin
            st_nxt = ats_pkg::ST_DLY_EVT;
          end else begin
            st_nxt = ats_pkg::ST_ACQ;
            trig_mark_nxt = 1'b1;
          end
        end
      end
      ats_pkg::ST_DLY_EVT: begin
        if (dly_evt_cnt_r >= i_dly_cfg.events) begin
          st_nxt = ats_pkg::ST_ACQ;
          trig_mark_nxt = 1'b1;
        end else if (dly_evt) begin
          dly_evt_cnt_nxt = dly_evt_cnt_r + 16'h0001;
        end
      end
      ats_pkg::ST_ACQ: begin
        // Main events ignored here
        if (post_cnt_r >= post_len) begin
          st_nxt = ats_pkg::ST_HOLDOFF;
          acq_done_nxt = 1'b1;
        end else if (i_sample_tick) begin
          post_cnt_nxt = post_cnt_r + 16'h0001;
        end
      end
      ats_pkg::ST_HOLDOFF: begin
        if (ho_zero) begin
          st_nxt = ats_pkg::ST_ARMED;
          pre_cnt_nxt = ats_pkg::REC_RST;
        end
      end
      default: begin
        st_nxt = ats_pkg::ST_ARMED;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output next values
  always_comb begin
    sample_we_nxt = i_sample_tick && ((st_nxt == ats_pkg::ST_ACQ &&
      st_r == ats_pkg::ST_ACQ) || st_r == ats_pkg::ST_ARMED ||
      st_r == ats_pkg::ST_DLY_TIME || st_r == ats_pkg::ST_DLY_EVT);
    status_nxt.armed = (st_nxt == ats_pkg::ST_ARMED);
    status_nxt.acquiring = (st_nxt == ats_pkg::ST_ACQ);
    status_nxt.holdoff = (st_nxt == ats_pkg::ST_HOLDOFF);
    status_nxt.delaying = (st_nxt == ats_pkg::ST_DLY_TIME) ||
      (st_nxt == ats_pkg::ST_DLY_EVT);
    status_nxt.pretrig_full = (pre_cnt_nxt >= pre_len);
    status_nxt.forced = forced_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; reset enters armed
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= ats_pkg::ST_ARMED;
      pre_cnt_r <= ats_pkg::REC_RST;
      post_cnt_r <= ats_pkg::REC_RST;
      dly_evt_cnt_r <= ats_pkg::REC_RST;
      force_pend_r <= 1'b0;
      forced_r <= 1'b0;
      sample_we_r <= 1'b0;
      trig_mark_r <= 1'b0;
      acq_done_r <= 1'b0;
      status_r <= '0;
    end else begin
      st_r <= st_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      post_cnt_r <= post_cnt_nxt;
      dly_evt_cnt_r <= dly_evt_cnt_nxt;
      force_pend_r <= force_pend_nxt;
      forced_r <= forced_nxt;
      sample_we_r <= sample_we_nxt;
      trig_mark_r <= trig_mark_nxt;
      acq_done_r <= acq_done_nxt;
      status_r <= status_nxt;
    end
  end

  // Flop-driven outputs
  assign o_sample_we = sample_we_r;
  assign o_trig_mark = trig_mark_r;
  assign o_acq_done = acq_done_r;
  assign o_state = st_r;
  assign o_status = status_r;

endmodule
`default_nettype wire

// file: shared/ats_pkg.sv
`default_nettype none
package ats_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and widths
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned REC_W = 16;
  localparam int unsigned PCT_W = 7;
  localparam int unsigned TB_W = 3;
  localparam int unsigned TB_NUM = 8;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

  ////////////////////////////////////////////////////////////////////////
  // Time base: length of one horizontal division per setting, in ns
  localparam int unsigned TB_DIV_NS [TB_NUM] = '{
    100, 200, 500, 1000, 2000, 5000, 10000, 20000
  };
  // Divisions waited in auto mode, and holdoff span limits in divisions
  localparam int unsigned AUTO_TO_DIVS = 10;
  localparam int unsigned HOLDOFF_MIN_DIVS = 1;
  localparam int unsigned HOLDOFF_MAX_DIVS = 5;

  // Division count at a time base turned into clock cycles, at least one
  function automatic int unsigned tb_cycles(input int unsigned divs,
                                            input int unsigned idx);
    int unsigned c;
    c = (divs * TB_DIV_NS[idx]) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [REC_W-1:0] REC_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    ST_ARMED,
    ST_DLY_TIME,
    ST_DLY_EVT,
    ST_ACQ,
    ST_HOLDOFF
  } ats_state_t;

  // Main trigger and record setup
  typedef struct packed {
    logic mode_auto;
    logic slope_fall;
    logic [TB_W-1:0] tb_sel;
    logic [PCT_W-1:0] holdoff_pct;
    logic [PCT_W-1:0] pretrig_pct;
    logic [REC_W-1:0] record_len;
  } ats_cfg_t;

  // Delayed time base setup
  typedef struct packed {
    logic dly_use;
    logic by_time;
    logic by_events;
    logic slope_fall;
    logic [CNT_W-1:0] time_cyc;
    logic [REC_W-1:0] events;
  } ats_dly_cfg_t;

  // Status seen by the host
  typedef struct packed {
    logic armed;
    logic acquiring;
    logic holdoff;
    logic delaying;
    logic pretrig_full;
    logic forced;
  } ats_status_t;

endpackage
`default_nettype wire

// file: logic/ats_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module ats_edge_detect (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_cmp,
  input wire logic i_slope_fall,
  output logic o_event
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic event_r;
  logic event_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Crossing in the chosen direction after the level comparator
  always_comb begin
    if (i_slope_fall) begin
      event_nxt = prev_r & ~sync2_r;
    end else begin
      event_nxt = ~prev_r & sync2_r;
    end
  end

  // Two-stage synchroniser, history and event flop
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      sync1_r <= i_cmp;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      event_r <= event_nxt;
    end
  end

  assign o_event = event_r;

endmodule
`default_nettype wire

// file: logic/ats_down_counter.sv
`timescale 1ns/1ps
`default_nettype none
module ats_down_counter (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [ats_pkg::CNT_W-1:0] i_load_val,
  input wire logic i_run,
  output logic o_zero
);

  logic [ats_pkg::CNT_W-1:0] cnt_r;
  logic [ats_pkg::CNT_W-1:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Load wins over counting; stops at zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_load_val;
    end else if (i_run && (cnt_r != ats_pkg::CNT_RST)) begin
      cnt_nxt = cnt_r - 24'h000001;
    end
  end

  // Count register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= ats_pkg::CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_zero = (cnt_r == ats_pkg::CNT_RST);

endmodule
`default_nettype wire

// file: bench/ats_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ats_seq_asserts (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_sample_tick,
  input wire logic o_sample_we,
  input wire logic o_trig_mark,
  input wire logic o_acq_done,
  input wire logic [2:0] o_state,
  input wire ats_pkg::ats_status_t o_status
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  ////////////////////////////////////////////////////////////////////////
  // Sequencing between armed, delay, acquiring and holdoff
  a_mark_enters_acq: assert property (
    o_trig_mark |-> o_state == 3'h3 && $past(o_state) != 3'h3)
    else $error("trigger mark without entry to acquiring");
  a_acq_ends_done: assert property (
    o_state == 3'h3 ##1 o_state != 3'h3 |-> o_acq_done)
    else $error("acquiring left without done pulse");
  a_done_to_hold: assert property (
    o_acq_done |-> o_state == 3'h4 && $past(o_state) == 3'h3)
    else $error("done pulse not followed by holdoff");
  a_hold_exit: assert property (
    o_state == 3'h4 |=> o_state == 3'h4 || o_state == 3'h0)
    else $error("holdoff left to a state other than armed");
  a_delay_exit: assert property (
    o_state == 3'h1 || o_state == 3'h2 |=> o_state inside {3'h1, 3'h2, 3'h3})
    else $error("delay state left to an illegal state");
  a_mark_single: assert property (
    o_trig_mark |=> !o_trig_mark)
    else $error("trigger mark longer than one cycle");
  a_we_gated: assert property (
    o_sample_we |-> $past(i_sample_tick) && $past(o_state) != 3'h4)
    else $error("sample write without tick or in holdoff");
  // The tick of the closing cycle lies past the record and is not written
  a_we_in_acq: assert property (
    $past(i_sample_tick) && $past(o_state) == 3'h3 && o_state == 3'h3
    |-> o_sample_we)
    else $error("tick during acquiring lost");
  a_status_map: assert property (
    $past(i_arst_n) |-> o_status.armed == (o_state == 3'h0) &&
    o_status.acquiring == (o_state == 3'h3) &&
    o_status.holdoff == (o_state == 3'h4))
    else $error("status bits disagree with state");

  // Main scenarios reached
  c_forced: cover property (o_trig_mark && o_status.forced);
  c_dly_both: cover property (o_state == 3'h1 ##1 o_state == 3'h2);
  c_dly_evt: cover property (o_state == 3'h2 ##1 o_state == 3'h3);
  c_rearm: cover property (o_state == 3'h4 ##1 o_state == 3'h0);
endmodule

bind ats_sequencer ats_seq_asserts chk_u (
  .i_sys_clk(i_sys_clk),
  .i_arst_n(i_arst_n),
  .i_sample_tick(i_sample_tick),
  .o_sample_we(o_sample_we),
  .o_trig_mark(o_trig_mark),
  .o_acq_done(o_acq_done),
  .o_state(o_state),
  .o_status(o_status)
);
`default_nettype wire

// file: bench/ats_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer_test;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_trig_cmp = 1'b0;
  logic i_dly_trig_cmp = 1'b0;
  logic i_sample_tick = 1'b0;
  logic i_force = 1'b0;
  ats_pkg::ats_cfg_t cfg;
  ats_pkg::ats_dly_cfg_t dcfg;
  logic o_sample_we;
  logic o_trig_mark;
  logic o_acq_done;
  logic [2:0] o_state;
  ats_pkg::ats_status_t o_status;
  logic f_mark = 1'b0;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_mark = 0;
  int n_done = 0;
  int n_we = 0;
  int t_mark = 0;
  int t_prev = 0;
  int ho_cnt = 0;
  int ho_len = 0;
  int m;
  int d;
  int l0;
  int l1;
  int h1;
  int w;

  ats_sequencer #(
    .P_AUTO_TO_CYC('{40, 80, 40, 40, 40, 40, 40, 40}),
    .P_HO_MIN_CYC('{default: 4}),
    .P_HO_MAX_CYC('{default: 20})
  ) dut_u (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_trig_cmp(i_trig_cmp),
    .i_dly_trig_cmp(i_dly_trig_cmp),
    .i_sample_tick(i_sample_tick),
    .i_force(i_force),
    .i_cfg(cfg),
    .i_dly_cfg(dcfg),
    .o_sample_we(o_sample_we),
    .o_trig_mark(o_trig_mark),
    .o_acq_done(o_acq_done),
    .o_state(o_state),
    .o_status(o_status)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock
  always #(ats_pkg::CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;

  // Event log just after each edge, holdoff length and hang guard
  always @(posedge i_sys_clk) begin
    #1;
    cyc++;
    if (o_trig_mark === 1'b1) begin
      n_mark++;
      t_prev = t_mark;
      t_mark = cyc;
      f_mark = o_status.forced;
    end
    if (o_acq_done === 1'b1) n_done++;
    if (o_sample_we === 1'b1) n_we++;
    if (o_state === 3'h4) begin
      ho_cnt++;
    end else if (ho_cnt != 0) begin
      ho_len = ho_cnt;
      ho_cnt = 0;
    end
    if (cyc >= 5000) begin
      n_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic trig(input logic v, input int e);
    int b;
    @(negedge i_sys_clk);
    b = n_mark;
    i_trig_cmp = v;
    cyc_n(8);
    chk(n_mark - b, e);
  endtask

  task automatic wait_mark(output int l);
    int b;
    l = 0;
    b = n_mark;
    while (n_mark == b && l < 500) begin
      @(negedge i_sys_clk);
      l++;
    end
    if (l >= 500) chk(32'h0, 32'h1);
  endtask

  task automatic wait_st(input logic [2:0] s);
    int i;
    i = 0;
    while (o_state !== s && i < 500) begin
      @(negedge i_sys_clk);
      i++;
    end
    chk(o_state, s);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge i_sys_clk);
      i_sample_tick = 1'b1;
    end
    @(negedge i_sys_clk);
    i_sample_tick = 1'b0;
  endtask

  task automatic dpulse;
    @(negedge i_sys_clk);
    i_dly_trig_cmp = 1'b1;
    cyc_n(4);
    i_dly_trig_cmp = 1'b0;
    cyc_n(4);
  endtask

  task automatic rise_lat(output int l);
    trig(1'b0, 0);
    i_trig_cmp = 1'b1;
    wait_mark(l);
    wait_st(3'h0);
    cyc_n(6);
  endtask

  task automatic close_out;
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cfg = '0;
    cfg.record_len = 16'h0008;
    cfg.pretrig_pct = 7'h32;
    cfg.holdoff_pct = 7'h64;
    dcfg = '0;
    cyc_n(4);
    chk(o_state, 3'h0);
    i_arst_n = 1'b1;
    cyc_n(1);
    chk(o_status.armed, 1'b1);
    // Pretrigger of four samples must fill before acceptance
    ticks(3);
    chk(o_status.pretrig_full, 1'b0);
    trig(1'b1, 0);
    trig(1'b0, 0);
    ticks(1);
    chk(o_status.pretrig_full, 1'b1);
    trig(1'b1, 1);
    chk(f_mark, 1'b0);
    // Lockout while acquiring, four posttrigger samples
    trig(1'b0, 0);
    trig(1'b1, 0);
    w = n_we;
    ticks(3);
    chk(o_state, 3'h3);
    d = n_done;
    ticks(1);
    cyc_n(3);
    chk(n_done - d, 1);
    chk(n_we - w, 4);
    chk(o_state, 3'h4);
    trig(1'b0, 0);
    trig(1'b1, 0);
    wait_st(3'h0);
    cyc_n(2);
    h1 = ho_len;
    // Shortest holdoff versus longest
    i_sample_tick = 1'b1;
    cfg.holdoff_pct = 7'h00;
    trig(1'b0, 0);
    trig(1'b1, 1);
    wait_st(3'h4);
    wait_st(3'h0);
    cyc_n(2);
    chk(h1 - ho_len, 16);
    // Falling slope
    cfg.slope_fall = 1'b1;
    cyc_n(6);
    trig(1'b0, 1);
    wait_st(3'h0);
    cyc_n(6);
    trig(1'b1, 0);
    trig(1'b0, 1);
    wait_st(3'h0);
    cfg.slope_fall = 1'b0;
    cyc_n(6);
    // One force, one acquisition
    m = n_mark;
    i_force = 1'b1;
    cyc_n(1);
    i_force = 1'b0;
    cyc_n(12);
    chk(n_mark - m, 1);
    chk(f_mark, 1'b1);
    wait_st(3'h0);
    m = n_mark;
    cyc_n(100);
    chk(n_mark - m, 0);
    // Delay by time
    rise_lat(l0);
    dcfg.dly_use = 1'b1;
    dcfg.by_time = 1'b1;
    dcfg.time_cyc = 24'h000014;
    rise_lat(l1);
    chk((l1 - l0) inside {[20:23]}, 1);
    // Delay by three delayed edges
    dcfg.by_time = 1'b0;
    dcfg.by_events = 1'b1;
    dcfg.events = 16'h0003;
    trig(1'b0, 0);
    trig(1'b1, 0);
    chk(o_status.delaying, 1'b1);
    m = n_mark;
    dpulse();
    dpulse();
    chk(n_mark - m, 0);
    dpulse();
    cyc_n(4);
    chk(n_mark - m, 1);
    wait_st(3'h0);
    // Time then events: delayed edges in the time phase do not count
    dcfg.by_time = 1'b1;
    trig(1'b0, 0);
    trig(1'b1, 0);
    m = n_mark;
    repeat (4) dpulse();
    chk(n_mark - m, 0);
    dpulse();
    cyc_n(4);
    chk(n_mark - m, 1);
    wait_st(3'h0);
    dcfg.dly_use = 1'b0;
    // Auto timeout follows the time base
    cfg.mode_auto = 1'b1;
    i_trig_cmp = 1'b0;
    repeat (3) wait_mark(l0);
    d = t_mark - t_prev;
    chk(f_mark, 1'b1);
    cfg.tb_sel = 3'h1;
    repeat (3) wait_mark(l0);
    chk((t_mark - t_prev) - d, 40);
    // Events faster than the timeout keep triggers real
    repeat (4) begin
      cyc_n(15);
      i_trig_cmp = 1'b1;
      cyc_n(15);
      i_trig_cmp = 1'b0;
    end
    chk(f_mark, 1'b0);
    // An ignored event in holdoff still restarts the 80-cycle timeout:
    // 2 cycles wait, 3 of sync, 1 to load, then 80 plus 1 to fire
    wait_mark(l0);
    cyc_n(2);
    i_trig_cmp = 1'b1;
    wait_mark(l0);
    chk(t_mark - t_prev, 87);
    chk(f_mark, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
